// ### key_detect_pkg.sv
// Shared constants for the power-key press detector.
// Assumes a single 50 MHz system clock and a plain register port.
package key_detect_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_TIME_NS  = 1000000;
    localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_EVENT     = 8'h04;
    localparam logic [7:0] ADDR_EVENT_CLR = 8'h08;
    localparam logic [7:0] ADDR_MASK      = 8'h0c;
    localparam logic [7:0] ADDR_CONTROL   = 8'h10;
    localparam logic [7:0] ADDR_DELAY     = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STAT_LEVEL_BIT = 0;
    localparam int STAT_LOCK_BIT  = 1;
    localparam int STAT_SYSEN_BIT = 2;
    localparam int STAT_HOLD_BIT  = 3;
    localparam int STAT_SLEEP_BIT = 4;
    localparam int EV_KEY_BIT     = 0;
    localparam int CTRL_FSEL_LSB  = 0;
    localparam int CTRL_LOCK_BIT  = 2;
    localparam int CTRL_SYSEN_BIT = 3;
    localparam int CTRL_HOLD_BIT  = 4;
    localparam int CTRL_DEB_LSB   = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] FSEL_RST  = 2'h0;
    localparam logic       LOCK_RST  = 1'b0;
    localparam logic       SYSEN_RST = 1'b1;
    localparam logic       HOLD_RST  = 1'b0;
    localparam logic [2:0] DEB_RST   = 3'h2;
    localparam logic [7:0] DELAY_RST = 8'h64;
    localparam logic       MASK_RST  = 1'b0;

    // ------------------------------------------------------------
    // Function select codes and press states
    // ------------------------------------------------------------
    localparam logic [1:0] FSEL_EVENT     = 2'h0;
    localparam logic [1:0] FSEL_LOCK      = 2'h1;
    localparam logic [1:0] FSEL_SLEEP_STATE = 2'h2;
    localparam logic [1:0] FSEL_STANDBY   = 2'h3;

    typedef enum logic [2:0]
    {
        T_IDLE   = 3'b001,
        T_TIMING = 3'b010,
        T_HELD   = 3'b100
    } press_state_e;

endpackage : key_detect_pkg

// ### key_debounce.sv
// Debounce filter for the active-low power-key input.
// Assumes the input is synchronous to sys_clk and a 1 ms tick enable.
`timescale 1ns/1ns
`default_nettype none
module key_debounce
    import key_detect_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       raw_in,
    input  wire logic       tick,
    input  wire logic [2:0] deb_sel,
    output logic            level
);

    logic       level_reg;
    logic       level_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    always_comb
    begin
        level_next = level_reg;
        cnt_next   = cnt_reg;
        if (raw_in == level_reg)
        begin
            cnt_next = 3'h0;
        end
        else if (tick)
        begin
            if (cnt_reg == deb_sel) // [RULE_01]
            begin
                level_next = raw_in;
                cnt_next   = 3'h0;
            end
            else
            begin
                cnt_next = cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            level_reg <= 1'b1;
            cnt_reg   <= 3'h0;
        end
        else
        begin
            level_reg <= level_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level = level_reg;

    property p_deb_tick;
        @(posedge sys_clk) disable iff (srst)
        (level_reg != $past(level_reg)) |-> ($past(tick) && $past(raw_in) == level_reg);
    endproperty
    a_deb_tick: assert property (p_deb_tick) // [RULE_01]
        else $error("debounced level moved without a settled tick");

endmodule : key_debounce
`default_nettype wire

// ### press_timer.sv
// Press timer: measures each key press against the long-press time.
// Assumes a debounced active-high pressed level and a 1 ms tick enable.
`timescale 1ns/1ns
`default_nettype none
module press_timer
    import key_detect_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       pressed,
    input  wire logic       tick,
    input  wire logic [7:0] delay,
    output logic            press_pulse,
    output logic            short_pulse,
    output logic            long_pulse
);

    press_state_e state_reg;
    press_state_e state_next;
    logic [7:0]   cnt_reg;
    logic [7:0]   cnt_next;
    logic         press_next;
    logic         short_next;
    logic         long_next;
    logic [7:0]   limit;

    // Zero delay is treated as one tick; both end timing on the first tick
    assign limit = (delay == 8'h00) ? 8'h01 : delay;

    // ------------------------------------------------------------
    // Press state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        press_next = 1'b0;
        short_next = 1'b0;
        long_next  = 1'b0;
        case (state_reg)
            T_IDLE:
            begin
                if (pressed) // [RULE_16] [RULE_02]
                begin
                    state_next = T_TIMING;
                    cnt_next   = 8'h00;
                    press_next = 1'b1;
                end
            end
            T_TIMING:
            begin
                if (!pressed) // [RULE_02]
                begin
                    state_next = T_IDLE;
                    short_next = 1'b1;
                end
                else if (tick)
                begin
                    if (cnt_reg + 8'h01 >= limit) // [RULE_16]
                    begin
                        state_next = T_HELD;
                        long_next  = 1'b1;
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 8'h01;
                    end
                end
            end
            T_HELD:
            begin
                if (!pressed)
                begin
                    state_next = T_IDLE;
                end
            end
            default:
            begin
                state_next = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg   <= T_IDLE;
            cnt_reg     <= 8'h00;
            press_pulse <= 1'b0;
            short_pulse <= 1'b0;
            long_pulse  <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            press_pulse <= press_next;
            short_pulse <= short_next;
            long_pulse  <= long_next;
        end
    end

    property p_short_cause;
        @(posedge sys_clk) disable iff (srst)
        short_pulse |-> ($past(state_reg) == T_TIMING && !$past(pressed));
    endproperty
    a_short_cause: assert property (p_short_cause) // [RULE_02]
        else $error("short press pulse without a release during timing");

    property p_long_cause;
        @(posedge sys_clk) disable iff (srst)
        (state_reg == T_HELD && $past(state_reg) == T_TIMING) |-> long_pulse;
    endproperty
    a_long_cause: assert property (p_long_cause) // [RULE_16]
        else $error("held state entered without a long press pulse");

endmodule : press_timer
`default_nettype wire

// ### power_key_press_detector.sv
// Power-key press detector: debounce, press timing, events, interrupt
// and wake-up / power-down / standby requests to the power sequencer.
// Assumes a 50 MHz clock, a synchronous key input and a plain register port.
//
// Contract
// RULE_01 - The key input passes a debounce filter set by one shared debounce selection.
// RULE_02 - Falling and rising debounced edges are both detected and the press is timed.
// RULE_03 - Edge detection and press timing run in every power mode, sleep included.
// RULE_04 - The debounced key level is readable as key_level_status.
// RULE_05 - With key_event_mask set, no interrupt and no wake-up come from key events.
// RULE_06 - Select 00 flags an event on press, interrupts if unmasked, wakes from sleep.
// RULE_07 - Selects 01..11 start a timer on press and flag an event on an early release.
// RULE_08 - Select 01 flags an event and sets the lock when the long-press time is reached.
// RULE_09 - Select 10 on a long press flags, sets the lock and clears system enable.
// RULE_10 - Select 11 on a short press also clears system enable and sets low-power hold.
// RULE_11 - Select 11 on a long press flags, sets lock, clears system enable and hold.
// RULE_12 - While the lock is set a short press produces no wake-up.
// RULE_13 - While the lock is set only a long press wakes the device from sleep.
// RULE_14 - Software must clear the lock before sleep if short-press wake-up is wanted.
// RULE_15 - The interrupt stays active while any unmasked event flag is pending.
// RULE_16 - A low debounced level is a press; the timer runs from press to release or limit.
// RULE_17 - The event flag holds until cleared, one event per qualifying press.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module power_key_press_detector
    import key_detect_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       power_key_input_n,
    input  wire logic       sleep_state,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    output logic            host_interrupt_line,
    output logic            wake_request,
    output logic            system_enable_bit,
    output logic            low_power_hold_bit,
    output logic            key_long_press_lock
);

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES_P - 1);

    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic        tick_reg;
    logic        tick_next;
    logic        key_level;
    logic        press_pulse;
    logic        short_pulse;
    logic        long_pulse;

    logic [1:0]  fsel_reg;
    logic [1:0]  fsel_next;
    logic        lock_reg;
    logic        lock_next;
    logic        sysen_reg;
    logic        sysen_next;
    logic        hold_reg;
    logic        hold_next;
    logic [2:0]  deb_reg;
    logic [2:0]  deb_next;
    logic [7:0]  delay_reg;
    logic [7:0]  delay_next;
    logic        mask_reg;
    logic        mask_next;
    logic        event_reg;
    logic        event_next;
    logic        irq_reg;
    logic        irq_next;
    logic        wake_reg;
    logic        wake_next;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;
    logic        qualify;
    logic        short_wake;
    logic        long_wake;

    // ------------------------------------------------------------
    // Millisecond tick divider
    // ------------------------------------------------------------
    always_comb
    begin
        tick_next     = 1'b0;
        tick_cnt_next = tick_cnt_reg + 16'h0001;
        if (tick_cnt_reg >= TICK_LAST)
        begin
            tick_cnt_next = 16'h0000;
            tick_next     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // Debounce and press timing
    // ------------------------------------------------------------
    // Neither sees sleep_state, so detection never stops [RULE_03]
    key_debounce u_debounce
    (
        .sys_clk (sys_clk),
        .srst    (srst),
        .raw_in  (power_key_input_n),
        .tick    (tick_reg),
        .deb_sel (deb_reg),
        .level   (key_level)
    );

    press_timer u_timer
    (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .pressed     (!key_level),
        .tick        (tick_reg),
        .delay       (delay_reg),
        .press_pulse (press_pulse),
        .short_pulse (short_pulse),
        .long_pulse  (long_pulse)
    );

    // ------------------------------------------------------------
    // Press qualification
    // ------------------------------------------------------------
    // Select 00 flags on the press itself; others on release or limit
    assign qualify = (fsel_reg == FSEL_EVENT) ? press_pulse
                                              : (short_pulse | long_pulse); // [RULE_06] [RULE_07]
    assign short_wake = !lock_reg &&
                        ((fsel_reg == FSEL_EVENT) ? press_pulse : short_pulse); // [RULE_12]
    // Unlocked select 00 already woke on the press edge
    assign long_wake  = long_pulse && (lock_reg || fsel_reg != FSEL_EVENT); // [RULE_13]

    // ------------------------------------------------------------
    // Control, event and register state
    // ------------------------------------------------------------
    always_comb
    begin
        fsel_next    = fsel_reg;
        lock_next    = lock_reg;
        sysen_next   = sysen_reg;
        hold_next    = hold_reg;
        deb_next     = deb_reg;
        delay_next   = delay_reg;
        mask_next    = mask_reg;
        event_next   = event_reg;
        rd_data_next = 8'h00;
        if (wr_en)
        begin
            case (addr)
                ADDR_CONTROL:
                begin
                    fsel_next  = wr_data[CTRL_FSEL_LSB +: 2];
                    lock_next  = wr_data[CTRL_LOCK_BIT]; // [RULE_14]
                    sysen_next = wr_data[CTRL_SYSEN_BIT];
                    hold_next  = wr_data[CTRL_HOLD_BIT];
                    deb_next   = wr_data[CTRL_DEB_LSB +: 3];
                end
                ADDR_DELAY:     delay_next = wr_data;
                ADDR_MASK:      mask_next  = wr_data[EV_KEY_BIT];
                ADDR_EVENT_CLR:
                begin
                    if (wr_data[EV_KEY_BIT])
                    begin
                        event_next = 1'b0;
                    end
                end
                default:        ;
            endcase
        end
        // Hardware updates come last so they beat a same-cycle register write
        if (qualify)
        begin
            event_next = 1'b1; // [RULE_17] [RULE_06] [RULE_07]
        end
        if (long_pulse && fsel_reg != FSEL_EVENT)
        begin
            lock_next = 1'b1; // [RULE_08]
        end
        if (long_pulse && fsel_reg == FSEL_SLEEP_STATE)
        begin
            sysen_next = 1'b0; // [RULE_09]
        end
        if (short_pulse && fsel_reg == FSEL_STANDBY)
        begin
            sysen_next = 1'b0; // [RULE_10]
            hold_next  = 1'b1;
        end
        if (long_pulse && fsel_reg == FSEL_STANDBY)
        begin
            sysen_next = 1'b0; // [RULE_11]
            hold_next  = 1'b0;
        end
        if (rd_en)
        begin
            case (addr)
                ADDR_STATUS:
                begin
                    rd_data_next[STAT_LEVEL_BIT] = key_level; // [RULE_04]
                    rd_data_next[STAT_LOCK_BIT]  = lock_reg;
                    rd_data_next[STAT_SYSEN_BIT] = sysen_reg;
                    rd_data_next[STAT_HOLD_BIT]  = hold_reg;
                    rd_data_next[STAT_SLEEP_BIT] = sleep_state;
                end
                ADDR_EVENT:   rd_data_next[EV_KEY_BIT] = event_reg;
                ADDR_MASK:    rd_data_next[EV_KEY_BIT] = mask_reg;
                ADDR_CONTROL: rd_data_next = {deb_reg, hold_reg, sysen_reg, lock_reg, fsel_reg};
                ADDR_DELAY:   rd_data_next = delay_reg;
                default:      rd_data_next = 8'h00;
            endcase
        end
        irq_next  = event_next && !mask_next; // [RULE_15] [RULE_05]
        wake_next = sleep_state && !mask_reg && (short_wake || long_wake); // [RULE_05] [RULE_06]
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            fsel_reg    <= FSEL_RST;
            lock_reg    <= LOCK_RST;
            sysen_reg   <= SYSEN_RST;
            hold_reg    <= HOLD_RST;
            deb_reg     <= DEB_RST;
            delay_reg   <= DELAY_RST;
            mask_reg    <= MASK_RST;
            event_reg   <= 1'b0;
            irq_reg     <= 1'b0;
            wake_reg    <= 1'b0;
            rd_data_reg <= 8'h00;
        end
        else
        begin
            fsel_reg    <= fsel_next;
            lock_reg    <= lock_next;
            sysen_reg   <= sysen_next;
            hold_reg    <= hold_next;
            deb_reg     <= deb_next;
            delay_reg   <= delay_next;
            mask_reg    <= mask_next;
            event_reg   <= event_next;
            irq_reg     <= irq_next;
            wake_reg    <= wake_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data             = rd_data_reg;
    assign host_interrupt_line = irq_reg;
    assign wake_request        = wake_reg;
    assign system_enable_bit   = sysen_reg;
    assign low_power_hold_bit  = hold_reg;
    assign key_long_press_lock = lock_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mask_no_wake;
        @(posedge sys_clk) disable iff (srst)
        wake_reg |-> !$past(mask_reg) && $past(sleep_state);
    endproperty
    a_mask_no_wake: assert property (p_mask_no_wake) // [RULE_05]
        else $error("wake-up raised while masked or awake");

    property p_sel00_press;
        @(posedge sys_clk) disable iff (srst)
        (press_pulse && fsel_reg == FSEL_EVENT && sleep_state && !mask_reg && !lock_reg)
            |=> event_reg && wake_reg;
    endproperty
    a_sel00_press: assert property (p_sel00_press) // [RULE_06]
        else $error("select 00 press did not flag and wake");

    property p_short_event;
        @(posedge sys_clk) disable iff (srst)
        (short_pulse && fsel_reg != FSEL_EVENT) |=> event_reg;
    endproperty
    a_short_event: assert property (p_short_event) // [RULE_07]
        else $error("early release did not flag an event");

    property p_sel01_long;
        @(posedge sys_clk) disable iff (srst)
        (long_pulse && fsel_reg == FSEL_LOCK) |=> event_reg && lock_reg;
    endproperty
    a_sel01_long: assert property (p_sel01_long) // [RULE_08]
        else $error("select 01 long press missed event or lock");

    property p_sel10_long;
        @(posedge sys_clk) disable iff (srst)
        (long_pulse && fsel_reg == FSEL_SLEEP_STATE) |=> lock_reg && !sysen_reg && event_reg;
    endproperty
    a_sel10_long: assert property (p_sel10_long) // [RULE_09]
        else $error("select 10 long press did not request power-down");

    property p_sel11_short;
        @(posedge sys_clk) disable iff (srst)
        (short_pulse && fsel_reg == FSEL_STANDBY) |=> !sysen_reg && hold_reg;
    endproperty
    a_sel11_short: assert property (p_sel11_short) // [RULE_10]
        else $error("select 11 short press did not request standby");

    property p_sel11_long;
        @(posedge sys_clk) disable iff (srst)
        (long_pulse && fsel_reg == FSEL_STANDBY) |=> lock_reg && !sysen_reg && !hold_reg;
    endproperty
    a_sel11_long: assert property (p_sel11_long) // [RULE_11]
        else $error("select 11 long press left enable or hold set");

    property p_lock_short;
        @(posedge sys_clk) disable iff (srst)
        (lock_reg && (short_pulse || press_pulse)) |=> !wake_reg;
    endproperty
    a_lock_short: assert property (p_lock_short) // [RULE_12]
        else $error("short press woke the device under lock");

    property p_lock_long;
        @(posedge sys_clk) disable iff (srst)
        (wake_reg && $past(lock_reg)) |-> $past(long_pulse);
    endproperty
    a_lock_long: assert property (p_lock_long) // [RULE_13]
        else $error("locked wake-up without a long press");

    property p_irq_level;
        @(posedge sys_clk) disable iff (srst)
        ##1 (irq_reg == (event_reg && !mask_reg));
    endproperty
    a_irq_level: assert property (p_irq_level) // [RULE_15]
        else $error("interrupt disagrees with pending unmasked flag");

    property p_flag_sticky;
        @(posedge sys_clk) disable iff (srst)
        (event_reg && !(wr_en && addr == ADDR_EVENT_CLR && wr_data[EV_KEY_BIT])) |=> event_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [RULE_17]
        else $error("event flag dropped without a clear");

    property p_level_read;
        @(posedge sys_clk) disable iff (srst)
        (rd_en && addr == ADDR_STATUS) |=> rd_data[STAT_LEVEL_BIT] == $past(key_level);
    endproperty
    a_level_read: assert property (p_level_read) // [RULE_04]
        else $error("status read shows wrong key level");

endmodule : power_key_press_detector
`default_nettype wire

// ### key_button.sv
// Push-button model for the active-low power-key pin.
// Assumes the bench commands press/release after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module key_button
(
    input  wire logic sys_clk,
    input  wire logic press,
    output logic      power_key_input_n = 1'b1
);
    logic last = 1'b0;
    // Pin keeps its old level for one cycle at each change, then follows; no bounce
    always @(posedge sys_clk)
    begin
        last <= press;
        power_key_input_n <= (press != last) ? press : ~press;
    end
endmodule : key_button
`default_nettype wire

// ### tb.sv
// Testbench for the power-key press detector.
// Assumes the button model and a 4-cycle tick to keep presses short.
`timescale 1ns/1ns
`default_nettype none
module tb
    import key_detect_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       btn = 1'b0;
    logic       sleep_state = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] rd_data;
    logic       power_key_input_n;
    logic       host_interrupt_line;
    logic       wake_request;
    logic       system_enable_bit;
    logic       low_power_hold_bit;
    logic       key_long_press_lock;
    int         fails = 0;
    int         tests_run = 0;
    int         wakes = 0;
    int         w0;
    int         sel;
    int         seed = 32'h0b99e1f4;

    key_button u_key_button (.sys_clk(sys_clk), .press(btn),
        .power_key_input_n(power_key_input_n));
    power_key_press_detector #(.TICK_CYCLES_P(4)) u_power_key_press_detector (
        .sys_clk(sys_clk), .srst(srst), .power_key_input_n(power_key_input_n),
        .sleep_state(sleep_state), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .host_interrupt_line(host_interrupt_line),
        .wake_request(wake_request), .system_enable_bit(system_enable_bit),
        .low_power_hold_bit(low_power_hold_bit), .key_long_press_lock(key_long_press_lock));

    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (wake_request === 1'b1) wakes <= wakes + 1;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask : rdc
    task automatic press(input int n);
        @(posedge sys_clk) btn <= 1'b1;
        repeat (n) @(posedge sys_clk);
        btn <= 1'b0;
        repeat (30) @(posedge sys_clk);
    endtask : press
    task automatic clr_event();
        rdc(ADDR_EVENT, 8'h01);
        wr(ADDR_EVENT_CLR, 8'h01);
        rdc(ADDR_EVENT, 8'h00);
    endtask : clr_event
    // Long press: lock set, enable kept only in select 01, hold dropped
    function automatic logic [7:0] exp_long(input int s);
        return (s == 1) ? 8'h06 : 8'h04;
    endfunction : exp_long
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        rdc(ADDR_STATUS, 8'h05);
        rdc(ADDR_CONTROL, 8'h48);
        rdc(ADDR_DELAY, 8'h64);
        rdc(8'h20, 8'h00);
        $display("test reset done");
        // Awake: the press still flags an event, but no wake-up follows
        w0 = wakes;
        press(24);
        chk(8'(wakes - w0), 8'h00);
        clr_event();
        $display("test awake press done");
        sleep_state <= 1'b1;
        wr(ADDR_DELAY, 8'h0a);
        rdc(ADDR_STATUS, 8'h15);
        w0 = wakes;
        press(24);
        chk({7'h0, host_interrupt_line}, 8'h01);
        chk(8'(wakes - w0), 8'h01);
        clr_event();
        chk({7'h0, host_interrupt_line}, 8'h00);
        wr(ADDR_MASK, 8'h01);
        w0 = wakes;
        press(24);
        chk({7'h0, host_interrupt_line}, 8'h00);
        chk(8'(wakes - w0), 8'h00);
        clr_event();
        wr(ADDR_MASK, 8'h00);
        $display("test select 00 done");
        for (sel = 1; sel < 4; sel++)
        begin
            wr(ADDR_CONTROL, 8'h48 | 8'(sel));
            press(20 + ($random(seed) & 7));
            chk({6'h0, system_enable_bit, low_power_hold_bit}, (sel == 3) ? 8'h01 : 8'h02);
            clr_event();
            wr(ADDR_CONTROL, 8'h48 | 8'(sel));
            w0 = wakes;
            press(80);
            chk({5'h0, key_long_press_lock, system_enable_bit, low_power_hold_bit}, exp_long(sel));
            chk(8'(wakes - w0), 8'h01);
            clr_event();
            w0 = wakes;
            press(20);
            chk(8'(wakes - w0), 8'h00);
            clr_event();
            $display("test select %0d done", sel);
        end
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
